/* File: scr_pkg.sv */
// Package for the system control register block: bit positions, reset
// values, port numbers and timing counts.
// Assumes a single 10 MHz core clock and an I/O port instruction strobe.
package scr_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_MIN_CYCLES = 5;
	localparam int RESET_CNT_W = 3;
	localparam int WRITE_DELAY_CYCLES = 2;
	localparam logic [2:0] PORT_CTRL = 3'h0;
	localparam logic [2:0] PORT_DATA = 3'h1;
	localparam int FLAG_LSB = 0;
	localparam int ENABLE_LSB = 4;
	localparam int UPPER_ACCESS_BIT = 8;
	localparam int SERIAL_ENABLE_BIT = 11;
	localparam int CLOCK_DIR_BIT = 15;
	localparam int NUM_IRQ = 4;
	localparam logic [15:0] RESET_FORCE_MASK = 16'h88f0;
	localparam logic [15:0] RESET_VALUE = 16'h8000;
	localparam logic [15:0] FLAG_MASK = 16'h000f;
	localparam logic [12:0] UPPER_RESET = 13'h0000;

	typedef struct packed {
		logic       strobe;
		logic       write;
		logic [2:0] port;
		logic [15:0] data;
	} scr_io_req_type;

	typedef enum logic [2:0] {
		SCR_RUN    = 3'b001,
		SCR_HOLD   = 3'b010,
		SCR_RESUME = 3'b100
	} scr_state_type;
endpackage

/* File: scr_core.sv */
// System control register with reset entry, interrupt flags and port
// 0 / port 1 access from the processor core.
// Assumes the core presents one-cycle I/O strobes on mclk_in; pins and
// interrupt sources are asynchronous and synchronised here.
//
// Contract
// - Reset needs pin low five cycles.
// - Reset halts execution and zeroes program counter.
// - Reset holds strobes high, data bus released.
// - Port address, program counter cleared after cycle.
// - Execution resumes one cycle after release; here halt falls three cycles after in_reset clears.
// - Reset releases serial clock and transmit lines.
// - Reset selects I/O port zero.
// - Reset clears serial register enable bit.
// - Reset sets serial clock direction bit.
// - Reset clears enables, keeps interrupt flags.
// - Reset points receive selector at register zero.
// - Reset changes only enables, bits eleven, fifteen.
// - Reset pin synchronised to clock.
// - Mode select low in reset drives branch pin.
// - Framing pulses level sensitive during transfer.
// - Four sources synchronised into one interrupt.
// - Events set flags regardless of enable.
// - Port zero write one clears flag.
// - Register mapped onto ports zero and one.
// - Written bits take effect after delay; here flag clears in bits 3:0 act on the write cycle.
// - Upper access bit redirects port one writes.
// - Enable bits four to seven gate sources.
`timescale 1ns/100ps
module scr_core (
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  reset_in,
	// Pins
	input  wire logic                  reset_in_low_in,
	input  wire logic                  memory_mode_select_in,
	input  wire logic [3:0]            irq_source_n_in,
	input  wire logic                  frame_active_in,
	// Core I/O port access
	input  wire scr_pkg::scr_io_req_type io_req_in,
	output logic [15:0]                read_data_out,
	// Core control
	output logic                       core_halt_out,
	output logic [11:0]                program_counter_clear_out,
	output logic [2:0]                 port_address_out,
	output logic                       master_irq_out,
	// Pin drive
	output logic                       data_read_strobe_n_out,
	output logic                       write_strobe_n_out,
	output logic                       data_bus_oe_out,
	output logic                       serial_clock_oe_out,
	output logic                       serial_tx_line_a_oe_out,
	output logic                       serial_tx_line_b_oe_out,
	output logic                       branch_test_pin_oe_out,
	output logic                       serial_active_out,
	// Register views
	output logic [15:0]                control_word_out,
	output logic [12:0]                upper_word_out,
	output logic                       rx_select_out
);
	logic [1:0] rst_sync;
	logic [2:0] low_count;
	logic       in_reset;
	logic       in_reset_q;
	scr_pkg::scr_state_type state;
	logic [15:0] system_control_word;
	logic [12:0] upper_word;
	logic [15:0] staged_word;
	logic [1:0]  delay_count;
	logic [3:0]  src_s1;
	logic [3:0]  src_s2;
	logic [3:0]  src_prev;
	logic [3:0]  event_hit;
	logic        port0_wr;
	logic        port1_wr;
	logic        frame_s1;
	logic        frame_s2;
	logic        mode_s1;
	logic        mode_s2;

	assign port0_wr = io_req_in.strobe && io_req_in.write
		&& io_req_in.port == scr_pkg::PORT_CTRL;
	assign port1_wr = io_req_in.strobe && io_req_in.write
		&& io_req_in.port == scr_pkg::PORT_DATA;
	assign event_hit = src_prev & ~src_s2;

	// The first stage only feeds the second; the low count sees stage two.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rst_sync <= 2'h3;
			frame_s1 <= 1'b0;
			frame_s2 <= 1'b0;
			mode_s1 <= 1'b1;
			mode_s2 <= 1'b1;
		end else begin
			rst_sync <= {rst_sync[0], reset_in_low_in};
			frame_s1 <= frame_active_in;
			frame_s2 <= frame_s1;
			mode_s1 <= memory_mode_select_in;
			mode_s2 <= mode_s1;
		end
	end

	// A low shorter than five cycles is treated as a glitch.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			low_count <= 3'h0;
			in_reset <= 1'b1;
		end else if (rst_sync[1]) begin
			low_count <= 3'h0;
			in_reset <= 1'b0;
		end else if (low_count ==
			3'(scr_pkg::RESET_MIN_CYCLES - 1)) begin
			in_reset <= 1'b1;
		end else begin
			low_count <= low_count + 3'h1;
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= scr_pkg::SCR_HOLD;
			in_reset_q <= 1'b1;
		end else begin
			in_reset_q <= in_reset;
			case (state)
				scr_pkg::SCR_RUN: begin
					if (in_reset)
						state <= scr_pkg::SCR_HOLD;
				end
				scr_pkg::SCR_HOLD: begin
					if (!in_reset)
						state <= scr_pkg::SCR_RESUME;
				end
				scr_pkg::SCR_RESUME: begin
					state <= in_reset ? scr_pkg::SCR_HOLD
						: scr_pkg::SCR_RUN;
				end
				default: state <= scr_pkg::SCR_HOLD;
			endcase
		end
	end

	// Halt and pin release follow in_reset straight away; halt falls only once state reaches SCR_RUN.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			core_halt_out <= 1'b1;
			data_read_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			data_bus_oe_out <= 1'b0;
			serial_clock_oe_out <= 1'b0;
			serial_tx_line_a_oe_out <= 1'b0;
			serial_tx_line_b_oe_out <= 1'b0;
			branch_test_pin_oe_out <= 1'b0;
			program_counter_clear_out <= 12'h000;
			port_address_out <= 3'h0;
		end else begin
			core_halt_out <= in_reset
				|| state != scr_pkg::SCR_RUN;
			data_read_strobe_n_out <= in_reset
				|| !(io_req_in.strobe && !io_req_in.write);
			write_strobe_n_out <= in_reset
				|| !(io_req_in.strobe && io_req_in.write);
			data_bus_oe_out <= !in_reset
				&& io_req_in.strobe && io_req_in.write;
			serial_clock_oe_out <= !in_reset
				&& !system_control_word[scr_pkg::CLOCK_DIR_BIT];
			serial_tx_line_a_oe_out <= !in_reset && serial_active_out;
			serial_tx_line_b_oe_out <= !in_reset && serial_active_out;
			if (in_reset && !mode_s2)
				branch_test_pin_oe_out <= 1'b1;
			else if (in_reset)
				branch_test_pin_oe_out <= 1'b0;
			if (in_reset_q) begin
				program_counter_clear_out <= 12'h000;
				port_address_out <= 3'h0;
			end else if (io_req_in.strobe) begin
				port_address_out <= io_req_in.port;
			end
		end
	end

	// Interrupt inputs are active low; an event is a falling edge.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			src_s1 <= 4'hf;
			src_s2 <= 4'hf;
			src_prev <= 4'hf;
		end else begin
			src_s1 <= irq_source_n_in;
			src_s2 <= src_s1;
			src_prev <= src_s2;
		end
	end

	// Lower register: writes to bits 15:4 are staged and land after the write delay; flag clears in bits 3:0 act at once.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			system_control_word <= scr_pkg::RESET_VALUE;
			staged_word <= scr_pkg::RESET_VALUE;
			delay_count <= 2'h0;
		end else begin
			if (port0_wr && !in_reset) begin
				staged_word <= io_req_in.data;
				delay_count <= 2'(scr_pkg::WRITE_DELAY_CYCLES);
			end else if (delay_count != 2'h0) begin
				delay_count <= delay_count - 2'h1;
			end
			if (in_reset) begin
				system_control_word <= (system_control_word
					& ~scr_pkg::RESET_FORCE_MASK)
					| scr_pkg::RESET_VALUE;
			end else if (delay_count == 2'h1) begin
				system_control_word[15:4] <= staged_word[15:4];
			end
			for (int i = 0; i < scr_pkg::NUM_IRQ; i++) begin
				if (event_hit[i])
					system_control_word[i] <= 1'b1;
				else if (port0_wr && io_req_in.data[i])
					system_control_word[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			upper_word <= scr_pkg::UPPER_RESET;
		else if (port1_wr
			&& system_control_word[scr_pkg::UPPER_ACCESS_BIT])
			upper_word <= io_req_in.data[12:0];
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_select_out <= 1'b0;
			master_irq_out <= 1'b0;
			serial_active_out <= 1'b0;
			read_data_out <= 16'h0000;
			control_word_out <= scr_pkg::RESET_VALUE;
			upper_word_out <= scr_pkg::UPPER_RESET;
		end else begin
			if (in_reset)
				rx_select_out <= 1'b0;
			master_irq_out <= !in_reset
				&& |(system_control_word[3:0]
				& system_control_word[7:4]);
			serial_active_out <= frame_s2
				&& system_control_word[scr_pkg::SERIAL_ENABLE_BIT];
			if (io_req_in.strobe && !io_req_in.write
				&& io_req_in.port == scr_pkg::PORT_CTRL)
				read_data_out <= system_control_word;
			control_word_out <= system_control_word;
			upper_word_out <= upper_word;
		end
	end

	a_flag_set_wins: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		event_hit[0] |=> system_control_word[0])
		else $error("flag lost on event");
	a_reset_forces_bits: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		in_reset |=> system_control_word[15] && !system_control_word[11]
		&& system_control_word[7:4] == 4'h0)
		else $error("reset bits not forced");
	a_halt_in_reset: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		in_reset |=> core_halt_out && data_read_strobe_n_out
		&& !data_bus_oe_out)
		else $error("pins active during reset");
	a_glitch_ignored: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		!in_reset && rst_sync[1] ##1 !rst_sync[1] [*3] |-> !in_reset)
		else $error("short reset pulse accepted");
	// Halt stays up through the resume state and falls three edges on.
	a_resume_after_cycle: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		$fell(in_reset) |-> core_halt_out
		##3 (!core_halt_out || in_reset))
		else $error("resume timing wrong");
	a_irq_gated: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		master_irq_out |-> $past(|(system_control_word[3:0]
		& system_control_word[7:4])))
		else $error("ungated interrupt");
	a_flag_clear: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		port0_wr && io_req_in.data[1] && !event_hit[1]
		|=> !system_control_word[1])
		else $error("flag not cleared");
	a_upper_gated: assert property (
		@(posedge mclk_in) disable iff (reset_in)
		$changed(upper_word) |-> $past(port1_wr)
		&& $past(system_control_word[8]))
		else $error("upper write without access");
endmodule

/* File: scr_core_model.sv */
// Core model: turns bench commands into one-cycle I/O port requests.
// Assumes the bench raises go_in for one cycle per request.
`timescale 1ns/100ps
module scr_core_model (
	// Clock
	input  wire logic                 mclk_in,
	// Command
	input  wire logic                 go_in,
	input  wire logic                 write_in,
	input  wire logic [2:0]           port_in,
	input  wire logic [15:0]          data_in,
	// Request
	output scr_pkg::scr_io_req_type   io_req_out
);
	// Idle data is inverted each cycle so stale data never looks valid.
	always_ff @(posedge mclk_in) begin
		io_req_out.strobe <= go_in;
		io_req_out.write  <= write_in;
		io_req_out.port   <= port_in;
		io_req_out.data   <= go_in ? data_in : ~io_req_out.data;
	end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the system control register block.
// Assumes the core model above stands in for the instruction core.
`timescale 1ns/100ps
module tb_top;
	logic                     mclk_in, reset_in, reset_in_low_in;
	logic                     memory_mode_select_in, frame_active_in;
	logic [3:0]               irq_source_n_in;
	scr_pkg::scr_io_req_type  io_req_in;
	logic [15:0]              read_data_out, control_word_out, dat;
	logic [11:0]              program_counter_clear_out;
	logic [12:0]              upper_word_out;
	logic [2:0]               port_address_out, port;
	logic                     core_halt_out, master_irq_out, go, wr;
	logic                     data_read_strobe_n_out, write_strobe_n_out;
	logic                     data_bus_oe_out, serial_clock_oe_out;
	logic                     serial_tx_line_a_oe_out, serial_tx_line_b_oe_out;
	logic                     branch_test_pin_oe_out, serial_active_out;
	logic                     rx_select_out;
	int                       err_total = 0;
	int                       n_compared = 0;

	scr_core uut (.mclk_in, .reset_in, .reset_in_low_in,
		.memory_mode_select_in, .irq_source_n_in, .frame_active_in,
		.io_req_in, .read_data_out, .core_halt_out,
		.program_counter_clear_out, .port_address_out, .master_irq_out,
		.data_read_strobe_n_out, .write_strobe_n_out, .data_bus_oe_out,
		.serial_clock_oe_out, .serial_tx_line_a_oe_out,
		.serial_tx_line_b_oe_out, .branch_test_pin_oe_out,
		.serial_active_out, .control_word_out, .upper_word_out,
		.rx_select_out);
	scr_core_model core (.mclk_in(mclk_in), .go_in(go), .write_in(wr),
		.port_in(port), .data_in(dat), .io_req_out(io_req_in));

	task automatic finish_test();
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Leaves room for the two-cycle write delay plus the register copy.
	task automatic io(input logic w, input logic [2:0] p, input logic [15:0] d);
		@(posedge mclk_in);
		go <= 1'b1;
		wr <= w;
		port <= p;
		dat <= d;
		@(posedge mclk_in);
		go <= 1'b0;
		repeat (6) @(posedge mclk_in);
	endtask

	task automatic wait_run();
		int i;
		for (i = 0; i < 20 && core_halt_out !== 1'b0; i++)
			@(posedge mclk_in);
		chk(core_halt_out, 1'b0);
	endtask

	// Sources are synchronised, so the level is held several cycles.
	task automatic pulse_src(input int b);
		irq_source_n_in[b] <= 1'b0;
		repeat (5) @(posedge mclk_in);
		irq_source_n_in[b] <= 1'b1;
		repeat (3) @(posedge mclk_in);
	endtask

	task automatic t_reset_values();
		chk(core_halt_out, 1'b1);
		chk(data_read_strobe_n_out, 1'b1);
		chk(write_strobe_n_out, 1'b1);
		chk(data_bus_oe_out, 1'b0);
		chk(serial_tx_line_a_oe_out, 1'b0);
		chk(serial_tx_line_b_oe_out, 1'b0);
		chk(control_word_out & 16'h88f0, 16'h8000);
		reset_in <= 1'b0;
		wait_run();
	endtask

	task automatic t_irq();
		io(1'b1, scr_pkg::PORT_CTRL, 16'h00f0);
		chk(control_word_out[7:4], 4'hf);
		pulse_src(0);
		chk(master_irq_out, 1'b1);
		io(1'b0, scr_pkg::PORT_CTRL, 16'h0000);
		chk(read_data_out[3:0], 4'h1);
		io(1'b1, scr_pkg::PORT_CTRL, 16'h00f1);
		chk(master_irq_out, 1'b0);
		io(1'b1, scr_pkg::PORT_CTRL, 16'h0000);
		pulse_src(1);
		chk(master_irq_out, 1'b0);
		io(1'b0, scr_pkg::PORT_CTRL, 16'h0000);
		chk(read_data_out[3:0], 4'h2);
	endtask

	task automatic t_upper();
		io(1'b1, scr_pkg::PORT_DATA, 16'h1c7f);
		chk(upper_word_out, 13'h0000);
		io(1'b1, scr_pkg::PORT_CTRL, 16'h0900);
		io(1'b1, scr_pkg::PORT_DATA, 16'h1c7f);
		chk(upper_word_out, 13'h1c7f);
		chk(port_address_out, scr_pkg::PORT_DATA);
		frame_active_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		chk(serial_active_out, 1'b1);
		frame_active_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		chk(serial_active_out, 1'b0);
	endtask

	task automatic t_pin_reset();
		reset_in_low_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		reset_in_low_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		chk(core_halt_out, 1'b0);
		memory_mode_select_in <= 1'b0;
		reset_in_low_in <= 1'b0;
		repeat (10) @(posedge mclk_in);
		chk(core_halt_out, 1'b1);
		chk(branch_test_pin_oe_out, 1'b1);
		chk(serial_clock_oe_out, 1'b0);
		chk(control_word_out, 16'h8102);
		memory_mode_select_in <= 1'b1;
		reset_in_low_in <= 1'b1;
		wait_run();
		chk(port_address_out, scr_pkg::PORT_CTRL);
		chk(program_counter_clear_out, 12'h000);
		chk(rx_select_out, 1'b0);
		io(1'b0, scr_pkg::PORT_CTRL, 16'h0000);
		chk(read_data_out[3:0], 4'h2);
		io(1'b1, scr_pkg::PORT_CTRL, 16'h0002);
		io(1'b0, scr_pkg::PORT_CTRL, 16'h0000);
		chk(read_data_out[3:0], 4'h0);
	endtask

	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	initial begin
		repeat (3000) @(posedge mclk_in);
		err_total++;
		finish_test();
	end

	initial begin
		reset_in = 1'b1;
		reset_in_low_in = 1'b1;
		memory_mode_select_in = 1'b1;
		frame_active_in = 1'b0;
		irq_source_n_in = 4'hf;
		go = 1'b0;
		wr = 1'b0;
		port = 3'h0;
		dat = 16'h0000;
		repeat (3) @(posedge mclk_in);
		t_reset_values();
		t_irq();
		t_upper();
		t_pin_reset();
		finish_test();
	end
endmodule
